/* File: rtl/spr_pkg.sv */
/*
 * spr_pkg: constants and types for the strobe pin receive sequencer.
 * Assumes a 100 MHz system clock; all timing derives from it.
 */
package spr_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 10;
    // sample period 1.6 us, expressed in ns
    localparam int unsigned SAMPLE_PERIOD_NS   = 1600;
    localparam int unsigned SAMPLE_CYCLES      = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned SLEEP_ENTRY_PERIODS = 2;
    // identifier notification rate 310 kBd
    localparam int unsigned NOTIFY_BAUD        = 310000;
    localparam int unsigned NOTIFY_BIT_CYCLES  = 1000000000 / (NOTIFY_BAUD * CLK_PERIOD_NS);
    localparam int unsigned BYTE_BITS          = 8;
    localparam logic [7:0]  IDENT_RESET        = 8'h00;
    localparam logic [7:0]  HEADER_RESET       = 8'h00;

    typedef enum logic [3:0] {
        SPR_CONFIG,
        SPR_OSC_SLEEP,
        SPR_OSC_SEARCH,
        SPR_OSC_HEADER,
        SPR_OSC_DATA,
        SPR_PIN_SLEEP,
        SPR_ID_SEARCH,
        SPR_ID_NOTIFY,
        SPR_HDR_SEARCH,
        SPR_DATA_OUT,
        SPR_EOM_PASS
    } spr_state_type;

    // decoded receive stream presented to the sequencer
    typedef struct packed {
        logic       bit_valid;  // one-cycle pulse per decoded bit
        logic       bit_value;
        logic       raw_data;   // undecoded demodulated level
        logic       eom;        // end of message pulse
    } spr_rx_type;

    // spi-side outputs of the device
    typedef struct packed {
        logic       mosi;
        logic       sclk;
    } spr_spi_type;
endpackage : spr_pkg

/* File: rtl/spr_sequencer.sv */
/*
 * spr_sequencer: receive control state machine for strobe pin and
 * oscillator strobed operation, with identifier and header search.
 * Assumes a decoded bit stream from the data manager on clk, and
 * asynchronous wake / config select pins from the host.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - oscillator mode sleep entry two periods, plus dummy
// - other transitions complete within one sample period
// - oscillator enable zero enters pin sleep
// - wake pin high leaves sleep to search
// - match word or complement advances to notify
// - send identifier byte at 310 kBd
// - wake low returns search/notify to sleep
// - header or complement advances to data output
// - data output, inverted after complemented header
// - wake low in data finishes current byte
// - after end of message pass raw data
// - config select low over one period forces config
// - pin sleep entry two periods plus byte
// - wake tied high keeps receive, discharge off
// - transitions on 1.6 us sample clock; code uses it only for config, sleep exit and wake-low exits
// - match word is Manchester-coded register value
// - data manager drives data and clock out
module spr_sequencer
    import spr_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = SAMPLE_CYCLES
)(
    input  wire logic        clk,                   // 100 MHz clock
    input  wire logic        reset,                 // synchronous, active high
    input  wire logic        wake_pin,              // strobe pin, asynchronous
    input  wire logic        config_select_n,       // config select pin, active low
    input  wire logic        strobe_osc_enable,     // oscillator enable field
    input  wire logic        data_manager_enable,   // data manager enable field
    input  wire logic        osc_period_end,        // strobe period ended pulse
    input  wire logic        dummy_byte,            // dummy byte shifted on exit
    input  wire logic [7:0]  ident_word_register,   // match word
    input  wire logic [7:0]  header_word,           // header word
    input  wire spr_rx_type  rx,                    // decoded stream
    output spr_spi_type      spi,                   // mosi / sclk
    output spr_state_type    state,                 // current state
    output logic             rx_power_on,           // receiver powered
    output logic             discharge_disable      // oscillator pull-down off
);
    // divider is 16 bits wide and needs at least two counts
    if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65536)
    begin : g_bad_div
        $error("SAMPLE_DIV out of range");
    end

    // sync chains, first stages read only by second stages
    logic wake_m_q, wake_s_q, cfg_m_q, cfg_s_q;
    spr_state_type st_q, st_d;
    logic [15:0] div_q, div_d;
    logic        tick;
    logic [15:0] code_q, code_d;   // last 16 Manchester half bits
    logic [7:0]  sh_q, sh_d;       // identifier notify shifter
    logic [3:0]  bit_q, bit_d;
    logic        inv_q, inv_d;
    logic        stop_q, stop_d;   // wake dropped in data output
    logic [1:0]  slp_q, slp_d;     // sleep-entry period count
    logic        cfg_lo_q, cfg_lo_d;
    logic [15:0] nbaud_q, nbaud_d;
    logic [3:0]  nbit_q, nbit_d;
    spr_spi_type spi_q, spi_d;

    function automatic logic [15:0] manch(input logic [7:0] w);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 8; i++)
            r[2*i +: 2] = w[i] ? 2'b10 : 2'b01;
        return r;
    endfunction : manch

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wake_m_q <= 1'b0;
            wake_s_q <= 1'b0;
            cfg_m_q  <= 1'b1;
            cfg_s_q  <= 1'b1;
        end
        else
        begin
            wake_m_q <= wake_pin;
            wake_s_q <= wake_m_q;
            cfg_m_q  <= config_select_n;
            cfg_s_q  <= cfg_m_q;
        end
    end

    logic [15:0] id_code, hdr_code, code_next;
    logic        id_hit, id_inv, hdr_hit, hdr_inv;
    always_comb
    begin
        id_code   = manch(ident_word_register);
        hdr_code  = manch(header_word);
        code_next = {code_q[14:0], rx.bit_value};
        id_hit    = rx.bit_valid && (code_next == id_code);
        id_inv    = rx.bit_valid && (code_next == ~id_code);
        hdr_hit   = rx.bit_valid && (code_next == hdr_code);
        hdr_inv   = rx.bit_valid && (code_next == ~hdr_code);
    end

    always_comb
    begin
        tick     = (div_q == 16'(SAMPLE_DIV - 1));
        div_d    = tick ? 16'h0000 : div_q + 16'h0001;
        st_d     = st_q;
        code_d   = rx.bit_valid ? code_next : code_q;
        sh_d     = sh_q;
        bit_d    = bit_q;
        inv_d    = inv_q;
        stop_d   = stop_q;
        slp_d    = slp_q;
        cfg_lo_d = cfg_lo_q;
        nbaud_d  = nbaud_q;
        nbit_d   = nbit_q;
        spi_d    = spi_q;
        if (tick)
            cfg_lo_d = ~cfg_s_q;
        if (tick && cfg_lo_q && !cfg_s_q)
        begin
            st_d  = SPR_CONFIG;
            slp_d = 2'd0;
            spi_d = '0;
        end
        else
        begin
            case (st_q)
                SPR_CONFIG:
                    if (tick && cfg_s_q)
                        st_d = strobe_osc_enable ? SPR_OSC_SEARCH : SPR_PIN_SLEEP;
                SPR_PIN_SLEEP, SPR_OSC_SLEEP:
                begin
                    if (tick && slp_q != 2'(SLEEP_ENTRY_PERIODS))
                        slp_d = slp_q + 2'd1;
                    if (tick && slp_q == 2'(SLEEP_ENTRY_PERIODS) && (wake_s_q ||
                        (st_q == SPR_OSC_SLEEP && osc_period_end)))
                        st_d = (st_q == SPR_PIN_SLEEP) ? SPR_ID_SEARCH : SPR_OSC_SEARCH;
                end
                SPR_ID_SEARCH, SPR_OSC_SEARCH:
                begin
                    if (id_hit || id_inv)
                    begin
                        st_d    = (st_q == SPR_ID_SEARCH) ? SPR_ID_NOTIFY : SPR_OSC_HEADER;
                        sh_d    = ident_word_register;
                        nbit_d  = 4'd0;
                        nbaud_d = 16'h0000;
                    end
                    else if (tick && st_q == SPR_ID_SEARCH && !wake_s_q)
                        st_d = SPR_PIN_SLEEP;
                    else if (st_q == SPR_OSC_SEARCH && osc_period_end)
                        st_d = SPR_OSC_SLEEP;
                end
                SPR_ID_NOTIFY:
                begin
                    spi_d.sclk = 1'b0;
                    spi_d.mosi = sh_q[7];
                    if (nbaud_q == 16'(NOTIFY_BIT_CYCLES - 1))
                    begin
                        nbaud_d = 16'h0000;
                        sh_d    = {sh_q[6:0], 1'b0};
                        nbit_d  = nbit_q + 4'd1;
                    end
                    else
                        nbaud_d = nbaud_q + 16'h0001;
                    if (tick && !wake_s_q)
                        st_d = SPR_PIN_SLEEP;
                    // host keeps wake high to proceed
                    else if (nbit_q == 4'(BYTE_BITS))
                        st_d = SPR_HDR_SEARCH;
                end
                SPR_HDR_SEARCH, SPR_OSC_HEADER:
                begin
                    if (hdr_hit || hdr_inv)
                    begin
                        st_d  = (st_q == SPR_HDR_SEARCH) ? SPR_DATA_OUT : SPR_OSC_DATA;
                        inv_d = hdr_inv;
                        bit_d = 4'd0;
                        stop_d = 1'b0;
                    end
                    else if (tick && st_q == SPR_HDR_SEARCH && !wake_s_q)
                        st_d = SPR_PIN_SLEEP;
                    else if (st_q == SPR_OSC_HEADER && osc_period_end)
                        st_d = SPR_OSC_SLEEP;
                end
                SPR_DATA_OUT, SPR_OSC_DATA:
                begin
                    if (!wake_s_q && st_q == SPR_DATA_OUT)
                        stop_d = 1'b1;
                    if (rx.bit_valid && data_manager_enable)
                    begin
                        spi_d.mosi = rx.bit_value ^ inv_q;
                        spi_d.sclk = 1'b1;
                        bit_d = (bit_q == 4'(BYTE_BITS - 1)) ? 4'd0 : bit_q + 4'd1;
                    end
                    else
                        spi_d.sclk = 1'b0;
                    if ((stop_q || (st_q == SPR_OSC_DATA && dummy_byte && osc_period_end))
                        && bit_q == 4'd0 && !rx.bit_valid)
                        st_d = (st_q == SPR_DATA_OUT) ? SPR_PIN_SLEEP : SPR_OSC_SLEEP;
                    else if (rx.eom)
                        st_d = SPR_EOM_PASS;
                end
                SPR_EOM_PASS:
                begin
                    spi_d.mosi = rx.raw_data;
                    spi_d.sclk = 1'b0;
                    if (tick && !wake_s_q)
                        st_d = SPR_PIN_SLEEP;
                end
                default:
                    st_d = SPR_CONFIG;
            endcase
            if (st_d != st_q && (st_d == SPR_PIN_SLEEP || st_d == SPR_OSC_SLEEP))
            begin
                slp_d = 2'd0;
                spi_d = '0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_q     <= SPR_CONFIG;
            div_q    <= 16'h0000;
            code_q   <= 16'h0000;
            sh_q     <= 8'h00;
            bit_q    <= 4'd0;
            inv_q    <= 1'b0;
            stop_q   <= 1'b0;
            slp_q    <= 2'd0;
            cfg_lo_q <= 1'b0;
            nbaud_q  <= 16'h0000;
            nbit_q   <= 4'd0;
            spi_q    <= '0;
        end
        else
        begin
            st_q     <= st_d;
            div_q    <= div_d;
            code_q   <= code_d;
            sh_q     <= sh_d;
            bit_q    <= bit_d;
            inv_q    <= inv_d;
            stop_q   <= stop_d;
            slp_q    <= slp_d;
            cfg_lo_q <= cfg_lo_d;
            nbaud_q  <= nbaud_d;
            nbit_q   <= nbit_d;
            spi_q    <= spi_d;
        end
    end

    assign state             = st_q;
    assign spi               = spi_q;
    // receiver off only once settled in pin sleep
    assign rx_power_on       = !(st_q == SPR_PIN_SLEEP && slp_q == 2'(SLEEP_ENTRY_PERIODS));
    assign discharge_disable = wake_s_q;
endmodule : spr_sequencer

`default_nettype wire

/* File: tb/spr_sequencer_asserts.sv */
/* spr_sequencer_asserts: port checks of spr_sequencer.
   Assumes strobe pin mode; bound onto the design. */
`timescale 1ns/10ps
`default_nettype none
module spr_sequencer_asserts
    import spr_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = SAMPLE_CYCLES
)(
    input wire logic          clk,               // clock
    input wire logic          reset,             // sync reset
    input wire logic          wake_pin,          // strobe pin
    input wire logic          config_select_n,   // config select
    input wire spr_spi_type   spi,               // spi outputs
    input wire spr_state_type state,             // state
    input wire logic          rx_power_on,       // rx power
    input wire logic          discharge_disable  // pull-down off
);
    logic [15:0] cfg_low_q, cfg_low_d, wake_low_q, wake_low_d;
    always_comb
    begin
        cfg_low_d  = config_select_n ? 16'h0000 : cfg_low_q + 16'h0001;
        wake_low_d = wake_pin ? 16'h0000 : wake_low_q + 16'h0001;
    end
    always_ff @(posedge clk)
    begin
        cfg_low_q  <= reset ? 16'h0000 : cfg_low_d;
        wake_low_q <= reset ? 16'h0000 : wake_low_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sleep_exit_a: assert property ($past(state) == SPR_PIN_SLEEP && state != SPR_PIN_SLEEP
        |-> state inside {SPR_ID_SEARCH, SPR_CONFIG}) else $error("bad sleep exit");
    id_advance_a: assert property ($past(state) == SPR_ID_SEARCH && state != SPR_ID_SEARCH
        |-> state inside {SPR_ID_NOTIFY, SPR_PIN_SLEEP, SPR_CONFIG}) else $error("bad search exit");
    data_exit_a: assert property ($past(state) == SPR_DATA_OUT && state != SPR_DATA_OUT
        |-> state inside {SPR_EOM_PASS, SPR_PIN_SLEEP, SPR_CONFIG}) else $error("bad data exit");
    eom_unclocked_a: assert property (state == SPR_EOM_PASS && $past(state) == SPR_EOM_PASS |-> !spi.sclk)
        else $error("clock during passthrough");
    notify_quiet_a: assert property (state == SPR_ID_NOTIFY |-> !spi.sclk)
        else $error("clock during notify");
    rx_powered_a: assert property (state inside {SPR_ID_SEARCH, SPR_DATA_OUT} |-> rx_power_on)
        else $error("receiver off while receiving");
    discharge_a: assert property ($stable(wake_pin) [*3] |-> discharge_disable == wake_pin)
        else $error("discharge control wrong");
    config_entry_a: assert property (cfg_low_q >= 3 * SAMPLE_DIV + 4 |-> state == SPR_CONFIG)
        else $error("config not entered");
    wake_sleep_a: assert property (wake_low_q >= 4 * SAMPLE_DIV + 4
        |-> !(state inside {SPR_ID_SEARCH, SPR_ID_NOTIFY})) else $error("search with wake low");
endmodule : spr_sequencer_asserts
bind spr_sequencer spr_sequencer_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) i_spr_sequencer_asserts (.clk(clk),
    .reset(reset), .wake_pin(wake_pin), .config_select_n(config_select_n), .spi(spi), .state(state),
    .rx_power_on(rx_power_on), .discharge_disable(discharge_disable));
`default_nettype wire

/* File: tb/spr_host_model.sv */
/* spr_host_model: host side; drives the wake pin, shifts clocked data.
   Assumes the bench raises want_rx while it wants reception. */
`timescale 1ns/10ps
`default_nettype none
module spr_host_model
    import spr_pkg::*;
(
    input  wire logic        clk,      // clock
    input  wire logic        want_rx,  // keep receiving
    input  wire logic        clear,    // clear bit count
    input  wire spr_spi_type spi,      // device spi
    output logic             wake_pin, // strobe pin
    output logic [7:0]       rx_byte,  // last bits
    output logic [7:0]       rx_count  // clocked bits
);
    assign wake_pin = want_rx;
    always @(posedge clk)
    begin
        if (clear)
            rx_count <= 8'h00;
        else if (spi.sclk)
        begin
            rx_byte  <= {rx_byte[6:0], spi.mosi};
            rx_count <= rx_count + 8'h01;
        end
    end
endmodule : spr_host_model
`default_nettype wire

/* File: tb/tb.sv */
/* tb: self-checking bench for spr_sequencer in strobe pin and oscillator modes.
   Assumes a shortened divider; the bench plays the demodulator. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import spr_pkg::*;
    localparam int unsigned DIV = 4;
    logic          clk, reset, cfg_n, want_rx, clear, wake_pin, rx_power_on, discharge_disable;
    logic          dm_en, osc_en, osc_end;
    logic [7:0]    id_w, rx_byte, rx_count;
    spr_rx_type    rx;
    spr_spi_type   spi;
    spr_state_type state;
    int            fail_count, check_count;
    spr_sequencer #(.SAMPLE_DIV(DIV)) i_spr_sequencer (.clk(clk), .reset(reset), .wake_pin(wake_pin),
        .config_select_n(cfg_n), .strobe_osc_enable(osc_en), .data_manager_enable(dm_en), .osc_period_end(osc_end),
        .dummy_byte(1'b0), .ident_word_register(id_w), .header_word(8'hc3), .rx(rx), .spi(spi),
        .state(state), .rx_power_on(rx_power_on), .discharge_disable(discharge_disable));
    spr_host_model i_spr_host_model (.clk(clk), .want_rx(want_rx), .clear(clear), .spi(spi),
        .wake_pin(wake_pin), .rx_byte(rx_byte), .rx_count(rx_count));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val
    // bounded wait, so a slow transition still passes
    task automatic cmp_state(input spr_state_type exp);
        for (int n = 0; n < 3000 && state !== exp; n++)
            @(negedge clk);
        cmp_val({4'h0, state}, {4'h0, exp});
    endtask : cmp_state
    function automatic logic [15:0] code(input logic [7:0] w);
        for (int i = 0; i < 8; i++)
            code[2*i +: 2] = w[i] ? 2'b10 : 2'b01;
    endfunction : code
    task automatic send_bits(input logic [15:0] w);
        for (int i = 15; i >= 0; i--)
        begin
            rx.bit_value = w[i];
            rx.bit_valid = 1'b1;
            @(negedge clk);
            rx.bit_valid = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask : send_bits
    task automatic reach_data(input logic cid, input logic chd);
        logic [7:0] got;
        want_rx = 1'b1;
        cmp_state(SPR_ID_SEARCH);
        cmp_val({7'h00, discharge_disable}, 8'h01);
        send_bits(code(cid ? ~id_w : id_w));
        cmp_state(SPR_ID_NOTIFY);
        for (int i = 7; i >= 0; i--)
        begin
            repeat (i == 7 ? NOTIFY_BIT_CYCLES / 2 : NOTIFY_BIT_CYCLES) @(negedge clk);
            got[i] = spi.mosi;
        end
        cmp_val(got, id_w);
        cmp_state(SPR_HDR_SEARCH);
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        send_bits(code(chd ? 8'h3c : 8'hc3));
        cmp_state(SPR_DATA_OUT);
    endtask : reach_data
    task automatic t_rx(input logic cid, input logic chd, input logic [15:0] d);
        reach_data(cid, chd);
        // data manager off: these bits must not be clocked out
        dm_en = 1'b0;
        send_bits(d);
        dm_en = 1'b1;
        send_bits(d);
        repeat (4) @(negedge clk);
        cmp_val(rx_count, 8'h10);
        cmp_val(rx_byte, chd ? ~d[7:0] : d[7:0]);
        rx.eom = 1'b1;
        @(negedge clk);
        rx.eom = 1'b0;
        cmp_state(SPR_EOM_PASS);
        rx.raw_data = 1'b1;
        repeat (4) @(negedge clk);
        cmp_val({7'h00, spi.mosi}, 8'h01);
        rx.raw_data = 1'b0;
        repeat (4) @(negedge clk);
        cmp_val({7'h00, spi.mosi}, 8'h00);
        cmp_val({7'h00, spi.sclk}, 8'h00);
        want_rx = 1'b0;
        cfg_n = 1'b0;
        cmp_state(SPR_CONFIG);
        cfg_n = 1'b1;
        rx.raw_data = 1'b0;
        cmp_state(SPR_PIN_SLEEP);
    endtask : t_rx
    task automatic t_drop;
        want_rx = 1'b1;
        cmp_state(SPR_ID_SEARCH);
        cfg_n = 1'b0;
        repeat (2) @(negedge clk);
        cfg_n = 1'b1;
        repeat (3 * DIV) @(negedge clk);
        cmp_val({4'h0, state}, {4'h0, SPR_ID_SEARCH});
        want_rx = 1'b0;
        cmp_state(SPR_PIN_SLEEP);
        reach_data(1'b0, 1'b0);
        fork
            send_bits(16'h9b6e);
            begin
                repeat (40) @(negedge clk);
                want_rx = 1'b0;
                repeat (16) @(negedge clk);
                cmp_val({4'h0, state}, {4'h0, SPR_DATA_OUT});
            end
        join
        cmp_state(SPR_PIN_SLEEP);
        cmp_val(rx_count, 8'h10);
    endtask : t_drop
    task automatic t_osc;
        cfg_n = 1'b0;
        cmp_state(SPR_CONFIG);
        osc_en = 1'b1;
        cfg_n = 1'b1;
        cmp_state(SPR_OSC_SEARCH);
        osc_end = 1'b1;
        @(negedge clk);
        osc_end = 1'b0;
        cmp_state(SPR_OSC_SLEEP);
        // wake high at once, yet sleep must last two periods
        want_rx = 1'b1;
        repeat (2 * DIV) @(negedge clk);
        cmp_val({4'h0, state}, {4'h0, SPR_OSC_SLEEP});
        cmp_state(SPR_OSC_SEARCH);
        want_rx = 1'b0;
    endtask : t_osc
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial
    begin
        {reset, cfg_n, want_rx, clear} = 4'hc;
        {dm_en, osc_en, osc_end} = 3'b100;
        rx = '0;
        id_w = 8'h5a;
        fail_count = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        cmp_state(SPR_CONFIG);
        reset = 1'b0;
        cmp_state(SPR_PIN_SLEEP);
        // receiver stays on until the second period has passed
        cmp_val({7'h00, rx_power_on}, 8'h01);
        repeat (3 * DIV + 2) @(negedge clk);
        cmp_val({7'h00, rx_power_on}, 8'h00);
        t_rx(1'b0, 1'b0, 16'ha55a);
        id_w = 8'h96;
        t_rx(1'b1, 1'b1, 16'h3cc3);
        t_drop;
        t_osc;
        close_out;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        close_out;
    end
endmodule : tb
`default_nettype wire
